//--- tps_pkg.sv
// constants and types shared by the transmit pulse shaper
`default_nettype none
package tps_pkg;
   // register offsets
   localparam logic [7:0] TPS_OFS_TEMPLATE = 8'h06;
   localparam logic [7:0] TPS_OFS_SCALE    = 8'h07;
   localparam logic [7:0] TPS_OFS_ACCESS   = 8'h08;
   localparam logic [7:0] TPS_OFS_SAMPLE   = 8'h09;
   localparam logic [7:0] TPS_OFS_INT_MASK = 8'h15;
   localparam logic [7:0] TPS_OFS_INT_STAT = 8'h1a;
   // field positions
   localparam int TPS_ACC_SUB_LSB  = 0;
   localparam int TPS_ACC_UI_LSB   = 4;
   localparam int TPS_ACC_DIR_BIT  = 6;
   localparam int TPS_ACC_TRIG_BIT = 7;
   localparam int TPS_OVF_BIT      = 0;
   // reset values
   localparam logic [3:0] TPS_RST_TEMPLATE = 4'h0;
   localparam logic [5:0] TPS_RST_SCALE    = 6'h21;
   // scaling: amplitude * scale * 31 / 1024, about 1/33 per step
   localparam logic [23:0] TPS_SCALE_RECIP = 24'h00_001f;
   localparam int          TPS_SCALE_SHIFT = 10;
   // template select codes
   localparam logic [3:0] TPS_T_E1_75   = 4'h0;
   localparam logic [3:0] TPS_T_E1_120  = 4'h1;
   localparam logic [3:0] TPS_T_T1_LO   = 4'h2;
   localparam logic [3:0] TPS_T_T1_HI   = 4'h6;
   localparam logic [3:0] TPS_T_LBO_LO  = 4'h8;
   localparam logic [1:0] TPS_T_RAM_TOP = 2'h3;
   // sizes
   localparam int TPS_SUBPHASES = 16;
   localparam int TPS_INTERVALS = 4;
   localparam int TPS_RAM_DEPTH = 64;
   localparam int TPS_FIFO_DEPTH = 32;
   localparam logic [5:0] TPS_AMP_MAX = 6'h3f;
   // e1 templates
   localparam logic [3:0] TPS_E1_EDGE_PH = 4'h3;
   localparam logic [3:0] TPS_E1_LVL_LO  = 4'h4;
   localparam logic [3:0] TPS_E1_LVL_HI  = 4'hb;
   localparam logic [6:0] TPS_E1_75_EDGE  = 7'h0c;
   localparam logic [6:0] TPS_E1_75_LVL   = 7'h30;
   localparam logic [6:0] TPS_E1_120_EDGE = 7'h0f;
   localparam logic [6:0] TPS_E1_120_LVL  = 7'h3c;
   // t1 templates: entries 0..15 first interval, 16..18 second interval
   localparam logic [4:0] TPS_TAIL_BASE = 5'h10;
   localparam logic [3:0] TPS_TAIL_LEN  = 4'h3;
   localparam logic [4:0][18:0][6:0] TPS_ROM_T1 = {
      {7'h41, 7'h42, 7'h43, 7'h44, 7'h47, 7'h49, 7'h4f, 7'h57, 7'h5e, 7'h5f,
       7'h29, 7'h2c, 7'h2d, 7'h2e, 7'h2f, 7'h33, 7'h38, 7'h3f, 7'h20},
      {7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h48, 7'h4c, 7'h53, 7'h58, 7'h58,
       7'h28, 7'h2a, 7'h2c, 7'h2d, 7'h2e, 7'h2f, 7'h35, 7'h3b, 7'h20},
      {7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h48, 7'h4b, 7'h50, 7'h53, 7'h57,
       7'h25, 7'h28, 7'h29, 7'h2a, 7'h2b, 7'h2c, 7'h2f, 7'h34, 7'h1f},
      {7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h48, 7'h4a, 7'h4d, 7'h4f, 7'h50,
       7'h25, 7'h26, 7'h27, 7'h28, 7'h29, 7'h2a, 7'h2c, 7'h2e, 7'h1b},
      {7'h00, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h47, 7'h49, 7'h4a, 7'h4a,
       7'h23, 7'h24, 7'h25, 7'h25, 7'h25, 7'h26, 7'h27, 7'h27, 7'h17}};
   // line attenuation gains, out of 64, for 0 / -7.5 / -15 / -22.5 dB
   localparam logic [3:0][6:0] TPS_LBO_GAIN = {7'h05, 7'h0b, 7'h1b, 7'h40};
   localparam int TPS_LBO_SHIFT = 6;
   // one encoded line symbol
   typedef struct packed {
      logic mark;
      logic negative;
   } tps_mark_t;
endpackage
`default_nettype wire

//--- tps_shaper.sv
// transmit pulse shaper: symbol fifo and shaper top
// What this block does
// [R1] software picks 0000 for E1 75 ohm, 0001 for 120 ohm, internal match
// [R2] software picks 0001 for both E1 cables with external matching
// [R3] five T1 short-haul presets chosen by the template select field
// [R4] four line attenuation grades 0, -7.5, -15, -22.5 dB by template select
// [R5] template select 11xx shapes pulses from the user waveform RAM
// [R6] a pulse spans four unit intervals, RAM interval index two bits
// [R7] sixteen sub-phase samples per interval, four-bit sub-phase index
// [R8] samples are 7-bit sign-magnitude, +63 to -63
// [R9] waveform RAM holds 64 entries, one per interval and sub-phase
// [R10] eleven standard templates held in ROM
// [R11] direction 0 writes sample value into RAM, 1 reads it back
// [R12] trigger bit performs the access at the current indices
// [R13] software sets indices, data, direction, then trigger, per entry
// [R14] in RAM mode each amplitude scale step scales output by fixed percent
// [R15] overlapping pulses beyond full scale latch the overflow flag
// [R16] overflow interrupt raised only when its mask bit enables it
// [R17] presets and attenuation grades ignore amplitude scaling
// [R18] amplitude scale resets to 100001, about 3 percent per step
// [R19] E1 75 ohm: 0001100 at sample 4, 0110000 at samples 5-12
// [R20] E1 120 ohm: 0001111 at sample 4, 0111100 at samples 5-12
// [R21] hardware control mode takes the template from four select pins
// [R22] transmit clock is 2.048 MHz for E1, 1.544 MHz for T1/J1
// [R23] marks output the template, sign inverted if negative, tails summed
`default_nettype none

module tps_fifo
   import tps_pkg::*;
#(
   parameter int WIDTH = 2,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   wire              empty = wr_ptr == rd_ptr;
   wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   wire              push  = in_valid && in_ready;
   wire              pop   = out_valid && out_ready;

   assign in_ready    = !full;
   assign out_valid   = !empty;
   assign out_data    = mem[rd_ptr[AW-1:0]];
   assign next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
   assign next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule

module tps_shaper
   import tps_pkg::*;
(
   // clock and reset
   input  wire logic       SYS_CLK,
   input  wire logic       RESET,
   // register port
   input  wire logic [7:0] REG_ADDR,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   input  wire logic [7:0] REG_WDATA,
   output logic      [7:0] REG_RDATA,
   // hardware control
   input  wire logic       HW_MODE,
   input  wire logic [3:0] TEMPLATE_PINS,
   // encoded symbol stream
   input  wire tps_mark_t  MARK_DATA,
   input  wire logic       MARK_VALID,
   output logic            MARK_READY,
   // line driver dac
   output logic      [6:0] DAC_SAMPLE,
   output logic            DAC_UI_START,
   // interrupt
   output logic            INT_OUT
);
   // rom lookup for preset and attenuation templates
   function automatic logic [6:0] rom_value(input logic [3:0] tsel,
                                            input logic [1:0] ui,
                                            input logic [3:0] ph);
      logic [18:0][6:0] tab;
      logic [4:0]       idx;
      logic             hit;
      logic [12:0]      att;
      tab = TPS_ROM_T1[0];
      idx = {1'b0, ph};
      hit = 1'b0;
      att = '0;
      rom_value = '0;
      if (tsel == TPS_T_E1_75 || tsel == TPS_T_E1_120) begin
         if (ui == 2'h0 && ph == TPS_E1_EDGE_PH) begin
            rom_value = (tsel == TPS_T_E1_75) ? TPS_E1_75_EDGE : TPS_E1_120_EDGE; // [R19] [R20]
         end else if (ui == 2'h0 && ph >= TPS_E1_LVL_LO && ph <= TPS_E1_LVL_HI) begin
            rom_value = (tsel == TPS_T_E1_75) ? TPS_E1_75_LVL : TPS_E1_120_LVL; // [R19] [R20]
         end
      end else begin
         if (tsel >= TPS_T_T1_LO && tsel <= TPS_T_T1_HI) begin
            tab = TPS_ROM_T1[3'(tsel - TPS_T_T1_LO)]; // [R3]
         end
         if (ui == 2'h0) begin
            hit = 1'b1;
         end else if (ui == 2'h1 && ph < TPS_TAIL_LEN) begin
            idx = TPS_TAIL_BASE + {1'b0, ph};
            hit = 1'b1;
         end
         if (hit) begin
            rom_value = tab[idx];
         end
         if (tsel >= TPS_T_LBO_LO) begin
            att = 13'(rom_value[5:0]) * 13'(TPS_LBO_GAIN[tsel[1:0]]); // [R4]
            rom_value = {rom_value[6], att[TPS_LBO_SHIFT +: 6]}; // [R4]
         end
      end
   endfunction

   // registers
   logic [3:0] template_select;
   logic [5:0] amplitude_scale;
   logic [1:0] interval_index;
   logic [3:0] subphase_index;
   logic       access_dir;
   logic       access_pending;
   logic [6:0] sample_value;
   logic       dac_overflow_mask;
   logic       dac_overflow_flag;
   logic [6:0] wave_ram [TPS_RAM_DEPTH];

   // register decode
   wire        wr_template = REG_WR && REG_ADDR == TPS_OFS_TEMPLATE;
   wire        wr_scale    = REG_WR && REG_ADDR == TPS_OFS_SCALE;
   wire        wr_access   = REG_WR && REG_ADDR == TPS_OFS_ACCESS;
   wire        wr_sample   = REG_WR && REG_ADDR == TPS_OFS_SAMPLE;
   wire        wr_mask     = REG_WR && REG_ADDR == TPS_OFS_INT_MASK;
   wire        wr_stat     = REG_WR && REG_ADDR == TPS_OFS_INT_STAT;
   wire [5:0]  ram_addr    = {interval_index, subphase_index}; // [R9]
   wire        ram_we      = access_pending && !access_dir; // [R11] [R12]
   wire        ram_re      = access_pending && access_dir; // [R11] [R12]
   wire [7:0]  access_rd   = {access_pending, access_dir, interval_index, subphase_index};

   logic [7:0] next_rdata;
   always_comb begin
      unique case (REG_ADDR)
         TPS_OFS_TEMPLATE: next_rdata = {4'h0, template_select};
         TPS_OFS_SCALE:    next_rdata = {2'h0, amplitude_scale};
         TPS_OFS_ACCESS:   next_rdata = access_rd;
         TPS_OFS_SAMPLE:   next_rdata = {1'b0, sample_value};
         TPS_OFS_INT_MASK: next_rdata = {7'h00, dac_overflow_mask};
         TPS_OFS_INT_STAT: next_rdata = {7'h00, dac_overflow_flag};
         default:          next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         template_select   <= TPS_RST_TEMPLATE;
         amplitude_scale   <= TPS_RST_SCALE; // [R18]
         interval_index    <= '0;
         subphase_index    <= '0;
         access_dir        <= 1'b0;
         dac_overflow_mask <= 1'b0;
         REG_RDATA         <= 8'h00;
      end else begin
         if (wr_template) begin
            template_select <= REG_WDATA[3:0];
         end
         if (wr_scale) begin
            amplitude_scale <= REG_WDATA[5:0];
         end
         if (wr_access) begin
            interval_index <= REG_WDATA[TPS_ACC_UI_LSB +: 2]; // [R6]
            subphase_index <= REG_WDATA[TPS_ACC_SUB_LSB +: 4]; // [R7]
            access_dir     <= REG_WDATA[TPS_ACC_DIR_BIT]; // [R11]
         end
         if (wr_mask) begin
            dac_overflow_mask <= REG_WDATA[TPS_OVF_BIT];
         end
         if (REG_RD) begin
            REG_RDATA <= next_rdata;
         end
      end
   end

   // ram access runs the cycle after the trigger write
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         access_pending <= 1'b0;
         sample_value   <= '0;
      end else begin
         access_pending <= wr_access && REG_WDATA[TPS_ACC_TRIG_BIT]; // [R12]
         if (ram_re) begin
            sample_value <= wave_ram[ram_addr]; // [R11]
         end else if (wr_sample) begin
            sample_value <= REG_WDATA[6:0]; // [R8]
         end
      end
   end

   for (genvar e = 0; e < TPS_RAM_DEPTH; e++) begin : g_ram
      always_ff @(posedge SYS_CLK) begin
         if (RESET) begin
            wave_ram[e] <= '0;
         end else if (ram_we && ram_addr == 6'(e)) begin
            wave_ram[e] <= sample_value; // [R9] [R11]
         end
      end
   end

   // symbol buffer
   logic      fifo_valid;
   tps_mark_t fifo_data;
   logic [3:0] phase;
   wire        ui_end = phase == 4'(TPS_SUBPHASES - 1);

   tps_fifo #(
      .WIDTH ($bits(tps_mark_t)),
      .DEPTH (TPS_FIFO_DEPTH)
   ) u_fifo (
      .clk       (SYS_CLK),
      .rst       (RESET),
      .in_valid  (MARK_VALID),
      .in_ready  (MARK_READY),
      .in_data   (MARK_DATA),
      .out_valid (fifo_valid),
      .out_ready (ui_end),
      .out_data  (fifo_data)
   );

   // symbol history: entry k started k intervals ago
   tps_mark_t hist [TPS_INTERVALS];
   tps_mark_t next_sym;
   assign next_sym = fifo_valid ? fifo_data : '0;

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         phase <= '0;
         for (int k = 0; k < TPS_INTERVALS; k++) begin
            hist[k] <= '0;
         end
      end else begin
         phase <= phase + 4'h1; // [R7]
         if (ui_end) begin
            hist[0] <= next_sym; // [R23]
            for (int k = 1; k < TPS_INTERVALS; k++) begin
               hist[k] <= hist[k-1]; // [R6] [R23]
            end
         end
      end
   end

   // template selection
   wire [3:0] active_tsel = HW_MODE ? TEMPLATE_PINS : template_select; // [R21]
   wire       ram_mode    = active_tsel[3:2] == TPS_T_RAM_TOP; // [R5]

   logic signed [9:0] contrib [TPS_INTERVALS];
   for (genvar k = 0; k < TPS_INTERVALS; k++) begin : g_tap
      wire [6:0] raw  = ram_mode ? wave_ram[{2'(k), phase}]
                                 : rom_value(active_tsel, 2'(k), phase); // [R5] [R10]
      wire       neg  = raw[6] ^ hist[k].negative; // [R8] [R23]
      wire [9:0] mag  = {4'h0, raw[5:0]};
      assign contrib[k] = !hist[k].mark ? 10'sd0
                        : neg ? $signed(-mag) : $signed(mag); // [R23]
   end

   wire signed [9:0]  pulse_sum = contrib[0] + contrib[1] + contrib[2] + contrib[3]; // [R23]
   wire signed [23:0] sum_w     = 24'(pulse_sum);
   wire signed [23:0] scale_w   = $signed({18'h0_0000, amplitude_scale});
   wire signed [23:0] prod      = sum_w * scale_w * $signed(TPS_SCALE_RECIP); // [R14]
   wire signed [23:0] scaled    = prod >>> TPS_SCALE_SHIFT; // [R14] [R18]
   wire signed [23:0] level     = ram_mode ? scaled : sum_w; // [R17]
   wire signed [23:0] amp_max   = $signed({18'h0_0000, TPS_AMP_MAX});
   wire               over_pos  = level > amp_max; // [R15]
   wire               over_neg  = level < -amp_max; // [R15]
   wire               overflow  = over_pos || over_neg;
   wire signed [23:0] abs_level = level[23] ? -level : level;

   logic [6:0] next_sample;
   always_comb begin
      if (over_pos) begin
         next_sample = {1'b0, TPS_AMP_MAX};
      end else if (over_neg) begin
         next_sample = {1'b1, TPS_AMP_MAX};
      end else begin
         next_sample = {level[23], abs_level[5:0]}; // [R8]
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         DAC_SAMPLE        <= '0;
         DAC_UI_START      <= 1'b0;
         dac_overflow_flag <= 1'b0;
      end else begin
         DAC_SAMPLE   <= next_sample;
         DAC_UI_START <= phase == 4'h0;
         if (overflow) begin
            dac_overflow_flag <= 1'b1; // [R15]
         end else if (wr_stat && REG_WDATA[TPS_OVF_BIT]) begin
            dac_overflow_flag <= 1'b0;
         end
      end
   end

   assign INT_OUT = dac_overflow_flag && dac_overflow_mask; // [R16]
endmodule
`default_nettype wire

//--- tps_shaper_assertions.sv
// port assertions for the transmit pulse shaper
`default_nettype none
module tps_shaper_chk
   import tps_pkg::*;
(
   // clock, reset
   input wire logic       SYS_CLK,
   input wire logic       RESET,
   // register port
   input wire logic [7:0] REG_ADDR,
   input wire logic       REG_WR,
   input wire logic       REG_RD,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   // stream, line, interrupt
   input wire logic       MARK_VALID,
   input wire logic       MARK_READY,
   input wire logic [6:0] DAC_SAMPLE,
   input wire logic       DAC_UI_START,
   input wire logic       INT_OUT
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   logic [9:0] idle;
   // cycles since a symbol was last taken
   always_ff @(posedge SYS_CLK) begin
      if (RESET || (MARK_VALID && MARK_READY)) idle <= 10'h000;
      else if (idle != 10'h3ff) idle <= idle + 10'h001;
   end
   property p_ui_period;
      DAC_UI_START |-> ##16 DAC_UI_START;
   endproperty
   a_ui_period: assert property (p_ui_period) else $error("interval start period");
   property p_ui_gap;
      DAC_UI_START |=> !DAC_UI_START [*8];
   endproperty
   a_ui_gap: assert property (p_ui_gap) else $error("interval start too soon");
   property p_mask_off;
      (REG_WR && REG_ADDR == TPS_OFS_INT_MASK && !REG_WDATA[0]) |=> !INT_OUT;
   endproperty
   a_mask_off: assert property (p_mask_off) else $error("masked interrupt high");
   property p_int_hold;
      (INT_OUT && !REG_WR) |=> INT_OUT;
   endproperty
   a_int_hold: assert property (p_int_hold) else $error("overflow not latched");
   property p_trig_pending;
      (REG_WR && REG_ADDR == TPS_OFS_ACCESS && REG_WDATA[7]) ##1
         (REG_RD && REG_ADDR == TPS_OFS_ACCESS) |=> REG_RDATA[7];
   endproperty
   a_trig_pending: assert property (p_trig_pending) else $error("trigger not pending");
   property p_sample_rsv;
      (REG_RD && REG_ADDR == TPS_OFS_SAMPLE) |=> !REG_RDATA[7];
   endproperty
   a_sample_rsv: assert property (p_sample_rsv) else $error("sample bit 7 set");
   property p_idle_zero;
      (idle > 10'h258) |-> DAC_SAMPLE[5:0] == 6'h00;
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("output after pulses end");
   property p_rdata_hold;
      !REG_RD |=> $stable(REG_RDATA);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule
bind tps_shaper tps_shaper_chk chk_u (
   .SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
   .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
   .MARK_VALID(MARK_VALID), .MARK_READY(MARK_READY), .DAC_SAMPLE(DAC_SAMPLE),
   .DAC_UI_START(DAC_UI_START), .INT_OUT(INT_OUT)
);
`default_nettype wire

//--- tps_encoder_model.sv
// line encoder model feeding marks to the shaper
`default_nettype none
module tps_encoder_model
   import tps_pkg::*;
(
   // symbol handshake
   input  wire logic      clk,
   output var  tps_mark_t mark_data,
   output var  logic      mark_valid,
   input  wire logic      mark_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   int stalls;
   initial begin
      mark_valid = 1'b0;
      mark_data  = 2'h0;
      stalls     = 0;
   end
   // n marks back to back, then gap idle cycles with the last mark's data inverted
   task automatic send(input int n, input logic neg, input int gap);
      for (int i = 0; i < n; i++) begin
         mark_data  = {1'b1, neg};
         mark_valid = 1'b1;
         while (!mark_ready) begin
            stalls++;
            @(negedge clk);
         end
         @(negedge clk);
      end
      mark_valid = 1'b0;
      mark_data  = ~mark_data;
      repeat (gap) @(negedge clk);
   endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the transmit pulse shaper
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin n_mismatch++; \
   $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_top
   import tps_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic       hw = 1'b0;
   logic [3:0] pins = 4'h0;
   logic [7:0] rdata;
   tps_mark_t  mdata;
   logic       mvalid, mready, ui_start, irq;
   logic [6:0] dac;
   int         n_mismatch = 0;
   int         checks = 0;
   int         cyc = 0;
   int         at = 0;
   logic [6:0] s [64];
   logic       u [64];
   logic [7:0] ra [7] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h15, 8'h1a, 8'h00};
   logic [7:0] re [7] = '{8'h00, 8'h21, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   always #2 clk = ~clk;
   tps_shaper dut_u (
      .SYS_CLK(clk), .RESET(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
      .REG_WDATA(wdata), .REG_RDATA(rdata), .HW_MODE(hw), .TEMPLATE_PINS(pins),
      .MARK_DATA(mdata), .MARK_VALID(mvalid), .MARK_READY(mready),
      .DAC_SAMPLE(dac), .DAC_UI_START(ui_start), .INT_OUT(irq)
   );
   tps_encoder_model enc_u (
      .clk(clk), .mark_data(mdata), .mark_valid(mvalid), .mark_ready(mready)
   );
   task automatic stop_test();
      if (n_mismatch == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      addr  = a;
      wdata = d;
      wr    = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      @(negedge clk);
   endtask
   task automatic rreg(input logic [7:0] a, output logic [7:0] d);
      addr = a;
      rd   = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      d  = rdata;
      @(negedge clk);
   endtask
   // access write, then read of the access register on the next edge
   task automatic trig(input logic [7:0] v, output logic [7:0] d);
      addr  = TPS_OFS_ACCESS;
      wdata = v;
      wr    = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      d  = rdata;
      @(negedge clk);
   endtask
   // one mark sampled into s and u, then time for its tail to clear
   task automatic grab(input logic ng);
      enc_u.send(1, ng, 0);
      for (int k = 0; k < 64; k++) begin
         s[k] = dac;
         u[k] = ui_start;
         @(negedge clk);
      end
      repeat (24) @(negedge clk);
   endtask
   // first nonzero sample from ph on
   task automatic find(input int ph);
      at = ph;
      while (at < 50 && s[at][5:0] == 6'h00) at++;
   endtask
   // one mark; edge at ph after interval start, then nl level samples
   task automatic pulse(input logic ng, input int ph, input logic [5:0] e,
                        input logic [5:0] l, input int nl);
      grab(ng);
      find(ph);
      `CHK("ui start", 1'b1, u[at-ph])
      `CHK("edge", {ng, e}, s[at])
      for (int k = 1; k <= nl; k++) `CHK("level", {ng, l}, s[at+k])
      `CHK("tail", 6'h00, s[at+nl+1][5:0])
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      logic [7:0] d;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      foreach (ra[j]) begin
         rreg(ra[j], d);
         `CHK("reset value", re[j], d)
      end
      for (int j = 0; j < 4; j++) begin
         wreg(TPS_OFS_SAMPLE, 8'h20 + 8'(j));
         trig({2'b10, 2'(j), 4'(j * 5)}, d);
         `CHK("pending", 1'b1, d[7])
      end
      for (int j = 0; j < 4; j++) begin
         wreg(TPS_OFS_SAMPLE, 8'h00);
         trig({2'b11, 2'(j), 4'(j * 5)}, d);
         rreg(TPS_OFS_SAMPLE, d);
         `CHK("ram readback", 8'h20 + 8'(j), d)
      end
      wreg(TPS_OFS_SCALE, 8'h10);
      for (int j = 0; j < 4; j++) begin
         hw   = j[1];
         pins = {3'b000, j[0]};
         wreg(TPS_OFS_TEMPLATE, j[1] ? 8'h0c : {7'h00, j[0]});
         if (j[0]) pulse(j[0] ^ j[1], 3, 6'h0f, 6'h3c, 8);
         else pulse(j[0] ^ j[1], 3, 6'h0c, 6'h30, 8);
      end
      hw = 1'b0;
      wreg(TPS_OFS_TEMPLATE, 8'h06);
      grab(1'b1);
      find(0);
      `CHK("t1 start", 7'h60, s[at])
      `CHK("t1 swing", 7'h1f, s[at+9])
      `CHK("t1 tail", 7'h03, s[at+16])
      wreg(TPS_OFS_TEMPLATE, 8'h09);
      grab(1'b0);
      find(0);
      `CHK("lbo start", 7'h09, s[at])
      `CHK("lbo peak", 7'h10, s[at+1])
      `CHK("lbo swing", 7'h44, s[at+9])
      wreg(TPS_OFS_TEMPLATE, 8'h0c);
      wreg(TPS_OFS_SCALE, 8'h21);
      pulse(1'b0, 0, 6'h1f, 6'h00, 0);
      wreg(TPS_OFS_SCALE, 8'h22);
      pulse(1'b0, 0, 6'h20, 6'h00, 0);
      wreg(TPS_OFS_SAMPLE, 8'h3f);
      trig(8'h80, d);
      trig(8'h90, d);
      enc_u.send(2, 1'b0, 80);
      `CHK("int masked", 1'b0, irq)
      rreg(TPS_OFS_INT_STAT, d);
      `CHK("overflow flag", 8'h01, d)
      wreg(TPS_OFS_INT_MASK, 8'h01);
      `CHK("int enabled", 1'b1, irq)
      wreg(TPS_OFS_INT_STAT, 8'h01);
      `CHK("int cleared", 1'b0, irq)
      wreg(TPS_OFS_INT_MASK, 8'h00);
      wreg(TPS_OFS_TEMPLATE, 8'h00);
      enc_u.send(40, 1'b1, 0);
      `CHK("fifo refused", 1'b1, enc_u.stalls > 0)
      repeat (700) @(negedge clk);
      `CHK("fifo drained", 1'b1, mready)
      stop_test();
   end
endmodule
`default_nettype wire
